//--- clock_gen_unit_pkg.sv
// Constants for the clock generator control registers
package clock_gen_unit_pkg;

	// ------------------------------------------------------------
	// Register indices; byte address is four times the index
	// ------------------------------------------------------------
	localparam logic [5:0] IDX_LOOP_CONTROL = 6'h36;
	localparam logic [5:0] IDX_LOOP_BANDWIDTH_CONTROL = 6'h37;
	localparam logic [5:0] IDX_FEEDBACK_FACTOR_LOW = 6'h38;
	localparam logic [5:0] IDX_FEEDBACK_FACTOR_HIGH = 6'h39;
	localparam logic [5:0] IDX_VCO_RANGE_LINEAR = 6'h3a;
	localparam logic [5:0] IDX_REFERENCE_DIVISOR_SELECT = 6'h3b;

	localparam logic [7:0] A_LOOP_CONTROL = {IDX_LOOP_CONTROL, 2'b00};
	localparam logic [7:0] A_BANDWIDTH = {IDX_LOOP_BANDWIDTH_CONTROL, 2'b00};
	localparam logic [7:0] A_FB_LOW = {IDX_FEEDBACK_FACTOR_LOW, 2'b00};
	localparam logic [7:0] A_FB_HIGH = {IDX_FEEDBACK_FACTOR_HIGH, 2'b00};
	localparam logic [7:0] A_VRS = {IDX_VCO_RANGE_LINEAR, 2'b00};
	localparam logic [7:0] A_RDS = {IDX_REFERENCE_DIVISOR_SELECT, 2'b00};

	// ------------------------------------------------------------
	// Field positions
	// ------------------------------------------------------------
	localparam int B_IE = 7;
	localparam int B_FLAG = 6;
	localparam int B_ON = 5;
	localparam int B_BCS = 4;
	localparam int B_PRE_HI = 3;
	localparam int B_PRE_LO = 2;
	localparam int B_VPR_HI = 1;
	localparam int B_VPR_LO = 0;
	localparam int B_AUTO = 7;
	localparam int B_LOCK = 6;
	localparam int B_ACQ = 5;

	// ------------------------------------------------------------
	// Reset values and special codes
	// ------------------------------------------------------------
	localparam logic RST_ON = 1'b1;
	localparam logic [7:0] RST_FB_LOW = 8'h40;
	localparam logic [3:0] RST_FB_HIGH = 4'h0;
	localparam logic [7:0] RST_VRS = 8'h40;
	localparam logic [3:0] RST_RDS = 4'h1;
	localparam logic [11:0] FB_ZERO = 12'h000;
	localparam logic [11:0] FB_ONE = 12'h001;
	localparam logic [7:0] VRS_ZERO = 8'h00;
	localparam logic [3:0] RDS_ZERO = 4'h0;
	localparam logic [3:0] RDS_ONE = 4'h1;
	localparam logic [1:0] SWITCH_EDGES = 2'h3;

	// Base clock selector states
	typedef enum logic [1:0] {
		ST_RUN = 2'b01,
		ST_SWITCH = 2'b10
	} sel_state_t;

endpackage

//--- pll_clock_control_registers.sv
// Clock generator control registers with APB slave and base clock selector
//
// Design decision made here: the APB register port.
`timescale 1ns/100ps
module pll_clock_control_registers
	import clock_gen_unit_pkg::*;
(
	input wire logic sys_clk,
	input wire logic sys_rst,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic crystal_clock,
	input wire logic vco_clock,
	input wire logic vco_locked,
	input wire logic vco_tracking,
	output logic loop_enable,
	output logic manual_bw,
	output logic capture_mode,
	output logic [1:0] scaler_exponent,
	output logic [1:0] vco_range_exponent,
	output logic [11:0] feedback_factor,
	output logic [7:0] vco_range_linear,
	output logic [3:0] reference_divisor,
	output logic base_clock_output,
	output logic loop_irq
);

	// ------------------------------------------------------------
	// Pin synchronisers
	// ------------------------------------------------------------
	logic x_s1, x_s2, x_s3;
	logic v_s1, v_s2, v_s3;
	logic lk_s1, lk_s2, lk_s3;
	logic trk_s1, trk_s2;

	// Third stages only feed edge detectors, never the first
	always_ff @(posedge sys_clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			{x_s1, x_s2, x_s3} <= 3'h0;
			{v_s1, v_s2, v_s3} <= 3'h0;
			{lk_s1, lk_s2, lk_s3} <= 3'h0;
			{trk_s1, trk_s2} <= 2'h0;
		end
		else
		begin
			{x_s1, x_s2, x_s3} <= {crystal_clock, x_s1, x_s2};
			{v_s1, v_s2, v_s3} <= {vco_clock, v_s1, v_s2};
			{lk_s1, lk_s2, lk_s3} <= {vco_locked, lk_s1, lk_s2};
			{trk_s1, trk_s2} <= {vco_tracking, trk_s1};
		end
	end

	logic x_rise, v_rise, lock_toggle;
	assign x_rise = x_s2 & ~x_s3;
	assign v_rise = v_s2 & ~v_s3;

	// ------------------------------------------------------------
	// APB decode
	// ------------------------------------------------------------
	logic wr_en, rd_setup, rd_acc, hit;
	logic wr_lc, wr_bw, wr_fl, wr_fh, wr_vrs, wr_rds;

	// Zero wait states; unmapped addresses answer with an error
	assign pready = 1'b1;
	assign wr_en = psel & penable & pwrite;
	assign rd_setup = psel & ~penable & ~pwrite;
	assign rd_acc = psel & penable & ~pwrite;
	assign pslverr = psel & penable & ~hit;
	assign wr_lc = wr_en & (paddr == A_LOOP_CONTROL);
	assign wr_bw = wr_en & (paddr == A_BANDWIDTH);
	assign wr_fl = wr_en & (paddr == A_FB_LOW);
	assign wr_fh = wr_en & (paddr == A_FB_HIGH);
	assign wr_vrs = wr_en & (paddr == A_VRS);
	assign wr_rds = wr_en & (paddr == A_RDS);

	// ------------------------------------------------------------
	// Loop control register
	// ------------------------------------------------------------
	logic ie_q, flag_q, flag_d, on_q, bcs_q;
	logic [1:0] pre_q, vpr_q;
	logic auto_q, acq_man_q;
	logic [7:0] fb_lo_q, vrs_q;
	logic [3:0] fb_hi_q, rds_q;
	logic vrs_zero, flag_clear;

	assign vrs_zero = (vrs_q == VRS_ZERO);

	// Power and select interlock: power held on while selected, select set only if power was already on
	always_ff @(posedge sys_clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			on_q <= RST_ON;
			bcs_q <= 1'b0;
		end
		else
		begin
			if (wr_lc)
			begin
				on_q <= bcs_q | pwdata[B_ON];
			end
			if (vrs_zero)
			begin
				bcs_q <= 1'b0;
			end
			else if (wr_lc)
			begin
				bcs_q <= on_q & pwdata[B_BCS];
			end
		end
	end

	// Exponents are frozen once the loop runs
	always_ff @(posedge sys_clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			pre_q <= 2'h0;
			vpr_q <= 2'h0;
		end
		else if (wr_lc && !on_q)
		begin
			pre_q <= pwdata[B_PRE_HI:B_PRE_LO];
			vpr_q <= pwdata[B_VPR_HI:B_VPR_LO];
		end
	end

	// Enable is forced clear while manual bandwidth is chosen
	always_ff @(posedge sys_clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			ie_q <= 1'b0;
		end
		else if (!auto_q)
		begin
			ie_q <= 1'b0;
		end
		else if (wr_lc)
		begin
			ie_q <= pwdata[B_IE];
		end
	end

	// Only a flag value actually returned on a read is cleared
	assign lock_toggle = auto_q & (lk_s2 ^ lk_s3);
	assign flag_clear = rd_acc & (paddr == A_LOOP_CONTROL) & prdata[B_FLAG];
	assign flag_d = lock_toggle | (flag_q & ~flag_clear);

	always_ff @(posedge sys_clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			flag_q <= 1'b0;
		end
		else
		begin
			flag_q <= flag_d;
		end
	end

	// ------------------------------------------------------------
	// Bandwidth control register
	// ------------------------------------------------------------
	// Manual capture value survives automatic periods untouched
	always_ff @(posedge sys_clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			auto_q <= 1'b0;
			acq_man_q <= 1'b0;
		end
		else if (wr_bw)
		begin
			auto_q <= pwdata[B_AUTO];
			if (!auto_q)
			begin
				acq_man_q <= pwdata[B_ACQ];
			end
		end
	end

	// ------------------------------------------------------------
	// Programming registers, write-protected while running
	// ------------------------------------------------------------
	always_ff @(posedge sys_clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			fb_lo_q <= RST_FB_LOW;
			fb_hi_q <= RST_FB_HIGH;
			vrs_q <= RST_VRS;
			rds_q <= RST_RDS;
		end
		else if (!on_q)
		begin
			if (wr_fl)
			begin
				fb_lo_q <= pwdata[7:0];
			end
			if (wr_fh)
			begin
				fb_hi_q <= pwdata[3:0];
			end
			if (wr_vrs)
			begin
				vrs_q <= pwdata[7:0];
			end
			if (wr_rds)
			begin
				rds_q <= pwdata[3:0];
			end
		end
	end

	// ------------------------------------------------------------
	// Read mux
	// ------------------------------------------------------------
	logic [7:0] rdata;
	logic settled, capture_rd;

	assign settled = auto_q & lk_s2;
	assign capture_rd = auto_q ? trk_s2 : acq_man_q;

	always_comb
	begin
		rdata = 8'h00;
		hit = 1'b1;
		case (paddr)
			A_LOOP_CONTROL:
			begin
				rdata = {ie_q, flag_q & auto_q, on_q, bcs_q, pre_q, vpr_q};
			end
			A_BANDWIDTH:
			begin
				rdata[B_AUTO] = auto_q;
				rdata[B_LOCK] = settled;
				rdata[B_ACQ] = capture_rd;
			end
			A_FB_LOW: rdata = fb_lo_q;
			A_FB_HIGH: rdata = {4'h0, fb_hi_q};
			A_VRS: rdata = vrs_q;
			A_RDS: rdata = {4'h0, rds_q};
			default: hit = 1'b0;
		endcase
	end

	// Read data sampled in the setup cycle, held through access
	always_ff @(posedge sys_clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			prdata <= 32'h0000_0000;
		end
		else if (rd_setup)
		begin
			prdata <= {24'h00_0000, rdata};
		end
	end

	// ------------------------------------------------------------
	// Outputs to the analog loop
	// ------------------------------------------------------------
	logic [11:0] fb_raw;
	assign fb_raw = {fb_hi_q, fb_lo_q};

	always_ff @(posedge sys_clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			loop_enable <= 1'b0;
			manual_bw <= 1'b1;
			capture_mode <= 1'b0;
			scaler_exponent <= 2'h0;
			vco_range_exponent <= 2'h0;
			feedback_factor <= FB_ONE;
			vco_range_linear <= RST_VRS;
			reference_divisor <= RST_RDS;
			loop_irq <= 1'b0;
		end
		else
		begin
			loop_enable <= on_q & ~vrs_zero;
			manual_bw <= ~auto_q;
			capture_mode <= acq_man_q;
			scaler_exponent <= pre_q;
			vco_range_exponent <= vpr_q;
			feedback_factor <= (fb_raw == FB_ZERO) ? FB_ONE : fb_raw;
			vco_range_linear <= vrs_q;
			reference_divisor <= (rds_q == RDS_ZERO) ? RDS_ONE : rds_q;
			loop_irq <= flag_q & ie_q & auto_q;
		end
	end

	// ------------------------------------------------------------
	// Base clock selector
	// ------------------------------------------------------------
	sel_state_t state_q;
	logic active_q, base_q;
	logic [1:0] cnt_x_q, cnt_v_q;

	// If the VCO has stopped, a switch away from it never ends
	always_ff @(posedge sys_clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			state_q <= ST_RUN;
			active_q <= 1'b0;
			cnt_x_q <= 2'h0;
			cnt_v_q <= 2'h0;
		end
		else
		begin
			case (state_q)
				ST_RUN:
				begin
					if (bcs_q != active_q)
					begin
						state_q <= ST_SWITCH;
						cnt_x_q <= 2'h0;
						cnt_v_q <= 2'h0;
					end
				end
				ST_SWITCH:
				begin
					if (x_rise && cnt_x_q != SWITCH_EDGES)
					begin
						cnt_x_q <= cnt_x_q + 2'h1;
					end
					if (v_rise && cnt_v_q != SWITCH_EDGES)
					begin
						cnt_v_q <= cnt_v_q + 2'h1;
					end
					if (cnt_x_q == SWITCH_EDGES && cnt_v_q == SWITCH_EDGES)
					begin
						active_q <= bcs_q;
						state_q <= ST_RUN;
					end
				end
				default: state_q <= ST_RUN;
			endcase
		end
	end

	// Toggling once per source edge halves the source rate
	always_ff @(posedge sys_clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			base_q <= 1'b0;
		end
		else if (state_q == ST_RUN && (active_q ? v_rise : x_rise))
		begin
			base_q <= ~base_q;
		end
	end

	assign base_clock_output = base_q;

	// ------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------
	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (sys_rst);

	sequence s_lc_write;
		psel && penable && pwrite && paddr == A_LOOP_CONTROL;
	endsequence

	sequence s_lc_read;
		rd_setup && paddr == A_LOOP_CONTROL ##1 rd_acc;
	endsequence

	a_ie_manual: assert property (!auto_q |=> !ie_q)
		else $error("enable set in manual mode");
	a_flag_set: assert property (lock_toggle |=> flag_q ##1
		(loop_irq || !$past(ie_q) || !$past(auto_q)))
		else $error("lock change lost");
	a_flag_hidden: assert property (!auto_q && rd_setup && paddr == A_LOOP_CONTROL
		|=> !prdata[B_FLAG])
		else $error("flag visible without auto");
	a_flag_clear: assert property (s_lc_read ##0 (prdata[B_FLAG] && !lock_toggle)
		|=> !flag_q)
		else $error("flag not cleared by read");
	a_power_kept: assert property ((bcs_q and s_lc_write) |=> on_q)
		else $error("power cleared while selected");
	a_bcs_guard: assert property (!on_q && !bcs_q |=> !bcs_q)
		else $error("select set with power off");
	a_switch_hold: assert property (state_q == ST_SWITCH |=> $stable(base_clock_output))
		else $error("base clock moved during switch");
	a_pre_locked: assert property (on_q |=> $stable(pre_q))
		else $error("scaler changed while running");
	a_vpr_locked: assert property (on_q |=> $stable(vpr_q))
		else $error("range exponent changed while running");
	a_acq_kept: assert property (auto_q |=> $stable(acq_man_q))
		else $error("manual capture value lost");
	a_fb_locked: assert property (on_q |=> $stable(fb_raw))
		else $error("feedback changed while running");
	a_vrs_zero: assert property (vrs_zero |=> !bcs_q ##1 !loop_enable)
		else $error("zero range did not disable");

endmodule

//--- pll_clock_control_registers_test.sv
// Self-checking bench for the clock generator control registers
`timescale 1ns/100ps
module pll_clock_control_registers_test import clock_gen_unit_pkg::*;;
	logic sys_clk = 1'b0;
	logic sys_rst = 1'b1;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	logic crystal_clock = 1'b0;
	logic vco_clock = 1'b0;
	logic vco_locked = 1'b0;
	logic vco_tracking = 1'b0;
	logic loop_enable;
	logic manual_bw;
	logic capture_mode;
	logic [1:0] scaler_exponent;
	logic [1:0] vco_range_exponent;
	logic [11:0] feedback_factor;
	logic [7:0] vco_range_linear;
	logic [3:0] reference_divisor;
	logic base_clock_output;
	logic loop_irq;
	logic [1:0] xc = 2'h0;
	logic [2:0] vc = 3'h0;
	logic [31:0] rdata;
	logic rerr;
	int miscompares = 0;
	int cmp_count = 0;
	int t;

	// ------------------------------------------------------------
	// Design under test
	// ------------------------------------------------------------
	pll_clock_control_registers DUT (
		.sys_clk(sys_clk), .sys_rst(sys_rst), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .crystal_clock(crystal_clock),
		.vco_clock(vco_clock), .vco_locked(vco_locked), .vco_tracking(vco_tracking),
		.loop_enable(loop_enable), .manual_bw(manual_bw), .capture_mode(capture_mode),
		.scaler_exponent(scaler_exponent), .vco_range_exponent(vco_range_exponent),
		.feedback_factor(feedback_factor), .vco_range_linear(vco_range_linear),
		.reference_divisor(reference_divisor), .base_clock_output(base_clock_output),
		.loop_irq(loop_irq)
	);

	// ------------------------------------------------------------
	// Clocks
	// ------------------------------------------------------------
	// System clock, 20 ns period
	always #10 sys_clk = ~sys_clk;

	// Crystal at a quarter, VCO at a sixth of the system rate; both derived from the system clock
	always @(posedge sys_clk)
	begin
		xc <= xc + 2'd1;
		vc <= (vc == 3'd5) ? 3'd0 : vc + 3'd1;
		crystal_clock <= xc[1];
		vco_clock <= (vc >= 3'd3);
	end

	// ------------------------------------------------------------
	// Bench tasks
	// ------------------------------------------------------------
	// Verdict and end of run
	task stop_test;
		$display("comparisons %0d mismatches %0d", cmp_count, miscompares);
		if (miscompares == 0 && cmp_count > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	task chk(input logic [31:0] got, input logic [31:0] exp, input string what);
		cmp_count++;
		if (got !== exp)
		begin
			miscompares++;
			$display("CHECK FAILED at %0t: %s got %h expected %h", $time, what, got, exp);
		end
	endtask

	// One APB transfer; request held until pready is seen at an edge
	task xfer(input logic [7:0] a, input logic wr, input logic [7:0] d);
		int n;
		n = 0;
		@(posedge sys_clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= {24'h0, d};
		@(posedge sys_clk);
		penable <= 1'b1;
		@(posedge sys_clk);
		while (pready !== 1'b1 && n < 20)
		begin
			@(posedge sys_clk);
			n++;
		end
		rdata = prdata;
		rerr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (n >= 20)
		begin
			miscompares++;
			$display("CHECK FAILED at %0t: bus answer never came", $time);
			stop_test;
		end
	endtask

	task wr(input logic [7:0] a, input logic [7:0] d);
		xfer(a, 1'b1, d);
	endtask

	task rd(input logic [7:0] a, input logic [7:0] exp);
		xfer(a, 1'b0, 8'h00);
		chk(rdata, {24'h0, exp}, "read data");
	endtask

	// Counts base clock changes over a number of cycles
	task toggles(input int cycles, output int n);
		logic last;
		n = 0;
		@(negedge sys_clk);
		last = base_clock_output;
		repeat (cycles)
		begin
			@(negedge sys_clk);
			if (base_clock_output !== last)
				n++;
			last = base_clock_output;
		end
	endtask

	// ------------------------------------------------------------
	// Main sequence
	// ------------------------------------------------------------
	initial
	begin
		repeat (20) @(posedge sys_clk);
		sys_rst <= 1'b0;
		rd(A_LOOP_CONTROL, 8'h20);
		rd(A_BANDWIDTH, 8'h00);
		rd(A_FB_LOW, 8'h40);
		rd(A_FB_HIGH, 8'h00);
		rd(A_VRS, 8'h40);
		rd(A_RDS, 8'h01);
		chk(32'(manual_bw), 32'h1, "manual mode");
		chk(32'(capture_mode), 32'h0, "capture reset");
		xfer(8'h00, 1'b0, 8'h00);
		chk(32'(rerr), 32'h1, "unmapped error");
		chk(rdata, 32'h0, "unmapped data");
		toggles(80, t);
		chk(32'(t > 18 && t < 22), 32'h1, "crystal half rate");
		$display("test reset done");
		// Running loop locks every programming field
		wr(A_LOOP_CONTROL, 8'h2f);
		rd(A_LOOP_CONTROL, 8'h20);
		wr(A_FB_LOW, 8'h12);
		wr(A_FB_HIGH, 8'h03);
		wr(A_VRS, 8'h11);
		wr(A_RDS, 8'h07);
		rd(A_FB_LOW, 8'h40);
		rd(A_FB_HIGH, 8'h00);
		rd(A_VRS, 8'h40);
		rd(A_RDS, 8'h01);
		$display("test protect done");
		// Loop off: select cannot be set, fields become writable
		wr(A_LOOP_CONTROL, 8'h00);
		wr(A_LOOP_CONTROL, 8'h10);
		rd(A_LOOP_CONTROL, 8'h00);
		chk(32'(loop_enable), 32'h0, "loop off");
		wr(A_FB_HIGH, 8'hfa);
		wr(A_FB_LOW, 8'h00);
		rd(A_FB_HIGH, 8'h0a);
		@(negedge sys_clk);
		chk(32'(feedback_factor), 32'ha00, "factor");
		wr(A_FB_HIGH, 8'h00);
		// Output register lags the field by one edge
		repeat (2) @(negedge sys_clk);
		chk(32'(feedback_factor), 32'h001, "factor zero");
		wr(A_RDS, 8'hf0);
		rd(A_RDS, 8'h00);
		chk(32'(reference_divisor), 32'h1, "divisor zero");
		wr(A_RDS, 8'h0c);
		rd(A_RDS, 8'h0c);
		for (int i = 0; i < 4; i++)
		begin
			// Range exponent three is never programmed
			wr(A_LOOP_CONTROL, {4'h0, 2'(i), (i == 3) ? 2'd0 : 2'(i)});
			rd(A_LOOP_CONTROL, {4'h0, 2'(i), (i == 3) ? 2'd0 : 2'(i)});
			chk(32'(scaler_exponent), 32'(i), "scaler");
			chk(32'(vco_range_exponent), (i == 3) ? 32'h0 : 32'(i), "range exp");
		end
		$display("test program done");
		// Linear range zero disables the loop and blocks the select
		wr(A_VRS, 8'h00);
		wr(A_LOOP_CONTROL, 8'h20);
		wr(A_LOOP_CONTROL, 8'h30);
		rd(A_LOOP_CONTROL, 8'h20);
		chk(32'(loop_enable), 32'h0, "range zero");
		chk(32'(vco_range_linear), 32'h0, "range out zero");
		wr(A_LOOP_CONTROL, 8'h00);
		wr(A_VRS, 8'h40);
		rd(A_VRS, 8'h40);
		chk(32'(vco_range_linear), 32'h40, "range out");
		// Manual bandwidth: capture bit cleared before the loop powers up
		wr(A_BANDWIDTH, 8'h00);
		rd(A_BANDWIDTH, 8'h00);
		wr(A_LOOP_CONTROL, 8'h20);
		wr(A_LOOP_CONTROL, 8'h30);
		// Skip the toggles already in flight when the select changes
		repeat (3) @(negedge sys_clk);
		toggles(9, t);
		chk(32'(t), 32'h0, "frozen switch");
		rd(A_LOOP_CONTROL, 8'h30);
		wr(A_LOOP_CONTROL, 8'h10);
		rd(A_LOOP_CONTROL, 8'h30);
		repeat (30) @(negedge sys_clk);
		toggles(120, t);
		chk(32'(t > 18 && t < 22), 32'h1, "vco half rate");
		$display("test select done");
		// Enable and capture bit in manual mode
		wr(A_BANDWIDTH, 8'h20);
		rd(A_BANDWIDTH, 8'h20);
		chk(32'(capture_mode), 32'h1, "manual capture");
		wr(A_LOOP_CONTROL, 8'hb0);
		rd(A_LOOP_CONTROL, 8'h30);
		// Automatic mode reports the loop state
		// Capture bit written as one so the switching write keeps it
		wr(A_BANDWIDTH, 8'ha0);
		rd(A_BANDWIDTH, 8'h80);
		chk(32'(capture_mode), 32'h1, "kept capture");
		wr(A_LOOP_CONTROL, 8'hb0);
		vco_tracking <= 1'b1;
		vco_locked <= 1'b1;
		repeat (8) @(negedge sys_clk);
		chk(32'(loop_irq), 32'h1, "irq raised");
		rd(A_BANDWIDTH, 8'he0);
		rd(A_LOOP_CONTROL, 8'hf0);
		repeat (2) @(negedge sys_clk);
		chk(32'(loop_irq), 32'h0, "irq cleared");
		rd(A_LOOP_CONTROL, 8'hb0);
		vco_locked <= 1'b0;
		repeat (8) @(negedge sys_clk);
		wr(A_LOOP_CONTROL, 8'hb0);
		rd(A_LOOP_CONTROL, 8'hf0);
		$display("test flag done");
		// Back to manual: flag hidden, enable cleared, capture restored
		vco_locked <= 1'b1;
		repeat (8) @(negedge sys_clk);
		wr(A_BANDWIDTH, 8'h00);
		rd(A_BANDWIDTH, 8'h20);
		wr(A_BANDWIDTH, 8'h20);
		rd(A_LOOP_CONTROL, 8'h30);
		chk(32'(loop_irq), 32'h0, "irq manual");
		rd(A_BANDWIDTH, 8'h20);
		$display("test manual done");
		stop_test;
	end
endmodule
